// File: inc/mgr_pkg.sv
// Constants, carriers and decode helpers for the mixer gain and record register bank
`default_nettype none
package mgr_pkg;

   localparam int          MGR_IDX_W        = 7;
   localparam int          MGR_DATA_W       = 16;
   localparam int          MGR_NUM_IN       = 5;
   localparam int          MGR_GAIN_W       = 5;
   localparam int          MGR_REC_W        = 4;
   localparam int          MGR_SRC_W        = 3;
   localparam int          MGR_SRC_N        = 8;

   // Register indices on the control link
   localparam logic [6:0]  MGR_IDX_MIC      = 7'h0E;
   localparam logic [6:0]  MGR_IDX_LINE     = 7'h10;
   localparam logic [6:0]  MGR_IDX_CD       = 7'h12;
   localparam logic [6:0]  MGR_IDX_VIDEO    = 7'h14;
   localparam logic [6:0]  MGR_IDX_AUX      = 7'h16;
   localparam logic [6:0]  MGR_IDX_PCM      = 7'h18;
   localparam logic [6:0]  MGR_IDX_SRC      = 7'h1A;
   localparam logic [6:0]  MGR_IDX_REC      = 7'h1C;

   // Field positions
   localparam int          MGR_MUTE_BIT     = 15;
   localparam int          MGR_BOOST20_BIT  = 6;
   localparam int          MGR_LEFT_LSB     = 8;
   localparam int          MGR_RIGHT_LSB    = 0;

   // Writable bits of each register; all others read as zero
   localparam logic [15:0] MGR_MIC_MASK     = 16'h805F;
   localparam logic [15:0] MGR_IN_MASK      = 16'h9F1F;
   localparam logic [15:0] MGR_SRC_MASK     = 16'h0707;
   localparam logic [15:0] MGR_REC_MASK     = 16'h8F0F;

   // Reset values
   localparam logic [15:0] MGR_MIC_RST      = 16'h8008;
   localparam logic [15:0] MGR_IN_RST       = 16'h8808;
   localparam logic [15:0] MGR_SRC_RST      = 16'h0000;
   localparam logic [15:0] MGR_REC_RST      = 16'h8000;

   // Gains are carried in half-dB units, so a 1.5 dB step is 3
   localparam logic [7:0]  MGR_STEP_HDB     = 8'h03;
   localparam logic [7:0]  MGR_TOP_HDB      = 8'h18;
   localparam logic [7:0]  MGR_BOOST10_HDB  = 8'h14;
   localparam logic [7:0]  MGR_BOOST20_HDB  = 8'h28;

   typedef struct packed {
      logic                     valid;
      logic                     rd;
      logic [MGR_IDX_W-1:0]     index;
      logic [MGR_DATA_W-1:0]    data;
   } mgr_cmd_s;

   typedef struct packed {
      logic                     valid;
      logic                     hit;
      logic [MGR_IDX_W-1:0]     index;
      logic [MGR_DATA_W-1:0]    data;
   } mgr_rsp_s;

   typedef struct packed {
      logic                     mic_mute;
      logic                     mic_boost_20;
      logic signed [7:0]        mic_gain_hdb;
      logic [MGR_NUM_IN-1:0]    in_mute;
      logic [MGR_NUM_IN-1:0][7:0] in_left_hdb;
      logic [MGR_NUM_IN-1:0][7:0] in_right_hdb;
      logic [MGR_SRC_N-1:0]     left_src_sel;
      logic [MGR_SRC_N-1:0]     right_src_sel;
      logic                     rec_mute;
      logic [7:0]               rec_left_hdb;
      logic [7:0]               rec_right_hdb;
   } mgr_ctl_s;

   typedef struct packed {
      logic [15:0]                 mic;
      logic [MGR_NUM_IN-1:0][15:0] stereo;
      logic [15:0]                 src;
      logic [15:0]                 rec;
      mgr_rsp_s                    rsp;
      mgr_ctl_s                    ctl;
   } mgr_state_s;

   localparam mgr_state_s MGR_STATE_RST = '{
      mic:    MGR_MIC_RST,
      stereo: {MGR_NUM_IN{MGR_IN_RST}},
      src:    MGR_SRC_RST,
      rec:    MGR_REC_RST,
      rsp:    '0,
      ctl:    '{mic_mute: 1'b1, mic_boost_20: 1'b0, mic_gain_hdb: 8'h00,
                in_mute: 5'h1F, in_left_hdb: '0, in_right_hdb: '0,
                left_src_sel: 8'h01, right_src_sel: 8'h01,
                rec_mute: 1'b1, rec_left_hdb: 8'h00, rec_right_hdb: 8'h00}
   };

   // Attenuating five-bit code: code 0 is the top gain, code 8 is unity
   function automatic logic [7:0] mgr_att_hdb(input logic [MGR_GAIN_W-1:0] code);
      mgr_att_hdb = MGR_TOP_HDB - ({3'h0, code} * MGR_STEP_HDB);
   endfunction

   function automatic logic [7:0] mgr_rec_hdb(input logic [MGR_REC_W-1:0] code);
      mgr_rec_hdb = {4'h0, code} * MGR_STEP_HDB;
   endfunction

   function automatic logic [7:0] mgr_mic_hdb(input logic [MGR_GAIN_W-1:0] code,
                                              input logic                  b20,
                                              input logic                  b10);
      logic [7:0] sum;
      sum = mgr_att_hdb(code);
      if (b20)
      begin
         sum = sum + MGR_BOOST20_HDB;
      end
      if (b10)
      begin
         sum = sum + MGR_BOOST10_HDB;
      end
      mgr_mic_hdb = sum;
   endfunction

   function automatic logic [MGR_SRC_N-1:0] mgr_src_onehot(input logic [MGR_SRC_W-1:0] s);
      mgr_src_onehot = 8'h01 << s;
   endfunction

endpackage
`default_nettype wire

// File: rtl/mgr_gain_decode.sv
// Decoder of one stereo input gain word into mute and per-channel gains
`timescale 1ns/10ps
`default_nettype none
module mgr_gain_decode
(
   input  wire logic [15:0] word,
   output logic             mute,
   output logic [7:0]       left_hdb,
   output logic [7:0]       right_hdb
);
   import mgr_pkg::*;

   // One mute bit silences both channels
   assign mute      = word[MGR_MUTE_BIT];
   assign left_hdb  = mgr_att_hdb(word[MGR_LEFT_LSB +: MGR_GAIN_W]);
   assign right_hdb = mgr_att_hdb(word[MGR_RIGHT_LSB +: MGR_GAIN_W]);

endmodule
`default_nettype wire

// File: rtl/mgr_bank.sv
// Mixer input gain, record source and record gain register bank
//
// Behaviour
// - Mic word: mute bit 15, 20 dB boost bit 6, 1.5 dB gain code bits 4..0.
// - Five stereo gain words at 10h..18h: line, CD, video, aux, PCM out.
// - Stereo word: bit 15 mutes both, left code 12..8, right 4..0, reset 8808h.
// - Stereo codes step 1.5 dB: 0 is +12 dB, 8 is 0 dB, 31 is -34.5 dB.
// - Record source word bits 10..8 choose the left ADC source.
// - Record source word bits 2..0 choose the right ADC source independently.
// - Sources: mic, CD, video, aux, line, stereo mix, mono mix, phone.
// - Record gain bit 15 silences both ADC inputs.
// - Left record gain bits 11..8, 1.5 dB steps from 0 dB upward.
// - Right record gain bits 3..0, same steps, code 15 is +22.5 dB.
// - Record gain word resets to 8000h: unity gain, muted.
`timescale 1ns/10ps
`default_nettype none
module mgr_bank
(
   input  wire logic           core_clk,
   input  wire logic           reset,
   input  wire mgr_pkg::mgr_cmd_s cmd,
   input  wire logic           mic_boost_10,
   output mgr_pkg::mgr_rsp_s   rsp,
   output mgr_pkg::mgr_ctl_s   ctl
);
   import mgr_pkg::*;

   mgr_state_s                  s_r;
   mgr_state_s                  s_nxt;
   logic [MGR_NUM_IN-1:0]       dec_mute;
   logic [MGR_NUM_IN-1:0][7:0]  dec_left;
   logic [MGR_NUM_IN-1:0][7:0]  dec_right;
   logic                        in_hit;
   logic [2:0]                  in_sel;
   logic                        wr;

   // Stereo words sit at every second index from line in to PCM out
   assign in_hit = (cmd.index >= MGR_IDX_LINE) && (cmd.index <= MGR_IDX_PCM) && !cmd.index[0];
   assign in_sel = 3'((cmd.index - MGR_IDX_LINE) >> 1);
   assign wr     = cmd.valid && !cmd.rd;

   genvar g;
   generate
      for (g = 0; g < MGR_NUM_IN; g++)
      begin : g_in
         mgr_gain_decode u_dec
         (
            .word      (s_r.stereo[g]),
            .mute      (dec_mute[g]),
            .left_hdb  (dec_left[g]),
            .right_hdb (dec_right[g])
         );
      end
   endgenerate

   always_comb
   begin
      s_nxt           = s_r;
      s_nxt.rsp.valid = 1'b0;
      if (cmd.valid && cmd.rd)
      begin
         // Reads answer one cycle later; misses return zero and let other banks answer
         s_nxt.rsp.valid = 1'b1;
         s_nxt.rsp.index = cmd.index;
         s_nxt.rsp.hit   = 1'b1;
         s_nxt.rsp.data  = 16'h0000;
         case (cmd.index)
            MGR_IDX_MIC: s_nxt.rsp.data = s_r.mic;
            MGR_IDX_SRC: s_nxt.rsp.data = s_r.src;
            MGR_IDX_REC: s_nxt.rsp.data = s_r.rec;
            default:
            begin
               if (in_hit)
               begin
                  s_nxt.rsp.data = s_r.stereo[in_sel];
               end
               else
               begin
                  s_nxt.rsp.hit = 1'b0;
               end
            end
         endcase
      end
      else if (wr)
      begin
         // Masks keep unused bits at zero whatever is written
         case (cmd.index)
            MGR_IDX_MIC: s_nxt.mic = cmd.data & MGR_MIC_MASK;
            MGR_IDX_SRC: s_nxt.src = cmd.data & MGR_SRC_MASK;
            MGR_IDX_REC: s_nxt.rec = cmd.data & MGR_REC_MASK;
            default:
            begin
               if (in_hit)
               begin
                  s_nxt.stereo[in_sel] = cmd.data & MGR_IN_MASK;
               end
            end
         endcase
      end
      // Analog controls follow the stored words one cycle later, glitch free
      s_nxt.ctl.mic_mute      = s_r.mic[MGR_MUTE_BIT];
      s_nxt.ctl.mic_boost_20  = s_r.mic[MGR_BOOST20_BIT];
      s_nxt.ctl.mic_gain_hdb  = mgr_mic_hdb(s_r.mic[MGR_RIGHT_LSB +: MGR_GAIN_W],
                                            s_r.mic[MGR_BOOST20_BIT], mic_boost_10);
      s_nxt.ctl.in_mute       = dec_mute;
      s_nxt.ctl.in_left_hdb   = dec_left;
      s_nxt.ctl.in_right_hdb  = dec_right;
      s_nxt.ctl.left_src_sel  = mgr_src_onehot(s_r.src[MGR_LEFT_LSB +: MGR_SRC_W]);
      s_nxt.ctl.right_src_sel = mgr_src_onehot(s_r.src[MGR_RIGHT_LSB +: MGR_SRC_W]);
      s_nxt.ctl.rec_mute      = s_r.rec[MGR_MUTE_BIT];
      s_nxt.ctl.rec_left_hdb  = mgr_rec_hdb(s_r.rec[MGR_LEFT_LSB +: MGR_REC_W]);
      s_nxt.ctl.rec_right_hdb = mgr_rec_hdb(s_r.rec[MGR_RIGHT_LSB +: MGR_REC_W]);
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         s_r <= MGR_STATE_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign rsp = s_r.rsp;
   assign ctl = s_r.ctl;

   a_mic_gain_decode:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_MIC) |-> ##2
      (ctl.mic_mute == $past(cmd.data[15], 2) &&
       int'(ctl.mic_gain_hdb) == 24 - 3 * int'($past(cmd.data[4:0], 2))
          + ($past(cmd.data[6], 2) ? 40 : 0) + ($past(mic_boost_10, 1) ? 20 : 0)))
   else $error("mic gain decode wrong");

   a_line_in_gain:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_LINE) |-> ##2
      (signed'(ctl.in_left_hdb[0]) == 8'(24 - 3 * int'($past(cmd.data[12:8], 2))) &&
       ctl.in_mute[0] == $past(cmd.data[15], 2)))
   else $error("line in gain not applied");

   a_pcm_out_gain:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_PCM) |-> ##2
      (ctl.in_right_hdb[4] == 8'(24 - 3 * int'($past(cmd.data[4:0], 2)))))
   else $error("pcm out gain not applied");

   a_left_src_sel:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_SRC) |-> ##2
      (ctl.left_src_sel == 8'(1 << $past(cmd.data[10:8], 2))))
   else $error("left record source wrong");

   a_right_src_sel:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_SRC) |-> ##2
      (ctl.right_src_sel == 8'(1 << $past(cmd.data[2:0], 2)) && $stable(ctl.rec_mute)))
   else $error("right record source wrong");

   a_reset_defaults:
   assert property (@(posedge core_clk) disable iff (reset)
      $past(reset) |-> (ctl.left_src_sel == 8'h01 && ctl.right_src_sel == 8'h01 &&
                        ctl.rec_mute && ctl.rec_left_hdb == 8'h00 && ctl.in_mute == 5'h1F))
   else $error("reset defaults wrong");

   a_rec_mute_gain:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_REC) |-> ##2
      (ctl.rec_mute == $past(cmd.data[15], 2) &&
       int'(ctl.rec_left_hdb) == 3 * int'($past(cmd.data[11:8], 2)) &&
       int'(ctl.rec_right_hdb) == 3 * int'($past(cmd.data[3:0], 2))))
   else $error("record gain wrong");

   a_read_back:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_REC) ##1 (cmd.valid && cmd.rd && cmd.index == MGR_IDX_REC)
      |=> (rsp.valid && rsp.hit && rsp.data == ($past(cmd.data, 2) & 16'h8F0F)))
   else $error("record gain read back wrong");

   a_read_timing:
   assert property (@(posedge core_clk) disable iff (reset)
      (cmd.valid && cmd.rd) |=> (rsp.valid && rsp.index == $past(cmd.index) &&
       (rsp.index != MGR_IDX_SRC || (rsp.data & 16'hF8F8) == 16'h0000)))
   else $error("read answer late or unused bits set");

   a_cd_gain_mute:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_CD) |-> ##2
      (ctl.in_mute[1] == $past(cmd.data[15], 2) &&
       ctl.in_left_hdb[1] == 8'(24 - 3 * int'($past(cmd.data[12:8], 2)))))
   else $error("cd gain not applied");

   a_video_gain:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_VIDEO) |-> ##2
      (ctl.in_mute[2] == $past(cmd.data[15], 2) &&
       ctl.in_right_hdb[2] == 8'(24 - 3 * int'($past(cmd.data[4:0], 2)))))
   else $error("video gain not applied");

   a_aux_gain:
   assert property (@(posedge core_clk) disable iff (reset)
      (wr && cmd.index == MGR_IDX_AUX) |-> ##2
      (ctl.in_left_hdb[3] == 8'(24 - 3 * int'($past(cmd.data[12:8], 2))) &&
       ctl.in_right_hdb[3] == 8'(24 - 3 * int'($past(cmd.data[4:0], 2)))))
   else $error("aux gain not applied");

   a_src_one_hot:
   assert property (@(posedge core_clk) disable iff (reset)
      $onehot(ctl.left_src_sel) && $onehot(ctl.right_src_sel))
   else $error("record source select not one-hot");

   a_rec_reset_value:
   assert property (@(posedge core_clk) disable iff (reset)
      $past(reset) |-> (s_r.rec == 16'h8000 && ctl.rec_mute &&
                        ctl.rec_left_hdb == 8'h00 && ctl.rec_right_hdb == 8'h00))
   else $error("record gain reset value wrong");

   a_miss_reads_zero:
   assert property (@(posedge core_clk) disable iff (reset)
      (cmd.valid && cmd.rd && (cmd.index < MGR_IDX_MIC || cmd.index > MGR_IDX_REC ||
       cmd.index[0])) |=> (!rsp.hit && rsp.data == 16'h0000))
   else $error("read outside the bank not zero");

   a_rsp_one_cycle:
   assert property (@(posedge core_clk) disable iff (reset)
      !(cmd.valid && cmd.rd) |=> !rsp.valid)
   else $error("read answer without a read");

endmodule
`default_nettype wire

// File: tb/mgr_ctrl_model.sv
// Link controller model that issues register commands and collects answers
`timescale 1ns/10ps
`default_nettype none
module mgr_ctrl_model
(
   input  wire logic              core_clk,
   output var mgr_pkg::mgr_cmd_s  cmd,
   input  wire mgr_pkg::mgr_rsp_s rsp
);
   import mgr_pkg::*;

   initial
   begin
      cmd = '{valid: 1'b0, rd: 1'b0, index: 7'h55, data: 16'hA5A5};
   end

   // Called at a falling edge; idle slots carry inverted data so stale words never match
   task automatic issue(input logic r, input logic [6:0] idx, input logic [15:0] d,
                        input logic hold);
      cmd = '{valid: 1'b1, rd: r, index: idx, data: d};
      @(negedge core_clk);
      if (!hold)
         cmd = '{valid: 1'b0, rd: ~r, index: ~idx, data: ~d};
   endtask

   task automatic read(input logic [6:0] idx, output mgr_rsp_s got);
      issue(1'b1, idx, 16'h0000, 1'b0);
      got = rsp;
   endtask
endmodule
`default_nettype wire

// File: tb/mgr_bank_bench.sv
// Self-checking bench for the mixer gain and record register bank
`timescale 1ns/10ps
`default_nettype none
module mgr_bank_bench;
   import mgr_pkg::*;
   logic        core_clk;
   logic        reset;
   logic        mic_boost_10;
   mgr_cmd_s    cmd;
   mgr_rsp_s    rsp;
   mgr_ctl_s    ctl;
   mgr_rsp_s    got;
   logic [15:0] w;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [6:0]  idx_tab [8] = '{MGR_IDX_MIC, MGR_IDX_LINE, MGR_IDX_CD, MGR_IDX_VIDEO,
                                 MGR_IDX_AUX, MGR_IDX_PCM, MGR_IDX_SRC, MGR_IDX_REC};
   logic [15:0] rst_tab [8] = '{16'h8008, 16'h8808, 16'h8808, 16'h8808, 16'h8808,
                                 16'h8808, 16'h0000, 16'h8000};
   logic [15:0] msk_tab [8] = '{16'h805F, 16'h9F1F, 16'h9F1F, 16'h9F1F, 16'h9F1F,
                                 16'h9F1F, 16'h0707, 16'h8F0F};
   int          code_tab [3] = '{0, 8, 31};
   logic [15:0] rec_tab [3] = '{16'h8F00, 16'h000F, 16'h0A05};
   logic [15:0] mic_tab [4] = '{16'h0040, 16'h801F, 16'h0048, 16'h0008};

   mgr_bank uut (.core_clk(core_clk), .reset(reset), .cmd(cmd),
                 .mic_boost_10(mic_boost_10), .rsp(rsp), .ctl(ctl));
   mgr_ctrl_model ctrl (.core_clk(core_clk), .cmd(cmd), .rsp(rsp));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic report_and_stop();
      if (n_mismatch == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Generous ceiling; the whole sequence needs about 140 cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic check(input logic [15:0] act, input logic [15:0] exp);
      total_checks++;
      if (act !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, act, exp);
      end
   endtask

   // Control outputs lag the register by one edge, so wait one more cycle
   task automatic wr(input logic [6:0] idx, input logic [15:0] d);
      ctrl.issue(1'b0, idx, d, 1'b0);
      @(negedge core_clk);
   endtask

   task automatic rdchk(input logic [6:0] idx, input logic [15:0] exp, input logic hit);
      ctrl.read(idx, got);
      check({14'h0, got.valid, got.hit}, {14'h0, 1'b1, hit});
      check({9'h0, got.index}, {9'h0, idx});
      check(got.data, exp);
      // Idle slot and next request must not share one time step
      @(negedge core_clk);
   endtask

   initial
   begin
      reset = 1'b1;
      mic_boost_10 = 1'b0;
      repeat (8) @(negedge core_clk);
      reset = 1'b0;
      check({11'h0, ctl.in_mute}, 16'h001F);
      check({ctl.left_src_sel, ctl.right_src_sel}, 16'h0101);
      check({15'h0, ctl.rec_mute}, 16'h0001);
      for (int i = 0; i < 8; i++)
         rdchk(idx_tab[i], rst_tab[i], 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         wr(idx_tab[i], 16'hFFFF);
         rdchk(idx_tab[i], msk_tab[i], 1'b1);
      end
      wr(7'h1E, 16'hFFFF);
      rdchk(7'h1E, 16'h0000, 1'b0);
      for (int i = 0; i < 5; i++)
         for (int k = 0; k < 3; k++)
         begin
            wr(idx_tab[i+1], {code_tab[k] != 8, 2'b00, 5'(code_tab[k]), 3'b000,
                              5'(31 - code_tab[k])});
            check({ctl.in_left_hdb[i], ctl.in_right_hdb[i]}, {8'(24 - 3 * code_tab[k]),
                  8'(24 - 3 * (31 - code_tab[k]))});
            check({15'h0, ctl.in_mute[i]}, {15'h0, code_tab[k] != 8});
         end
      for (int s = 0; s < 8; s++)
      begin
         wr(MGR_IDX_SRC, {5'h00, 3'(s), 5'h00, 3'(7 - s)});
         check({ctl.left_src_sel, ctl.right_src_sel},
               {8'h01 << s, 8'h01 << (7 - s)});
      end
      for (int k = 0; k < 3; k++)
      begin
         w = rec_tab[k];
         wr(MGR_IDX_REC, w);
         check({ctl.rec_left_hdb, ctl.rec_right_hdb},
               {8'(3 * w[11:8]), 8'(3 * w[3:0])});
         check({15'h0, ctl.rec_mute}, {15'h0, w[15]});
      end
      for (int k = 0; k < 4; k++)
      begin
         w = mic_tab[k];
         mic_boost_10 = (k == 0 || k == 3);
         wr(MGR_IDX_MIC, w);
         check({ctl.mic_mute, ctl.mic_boost_20, 6'h00, ctl.mic_gain_hdb},
               {w[15], w[6], 6'h00, 8'(24 - 3 * w[4:0] + (w[6] ? 40 : 0)
               + (mic_boost_10 ? 20 : 0))});
      end
      // Read right behind a write must already see the new word
      ctrl.issue(1'b0, MGR_IDX_REC, 16'hF305, 1'b1);
      rdchk(MGR_IDX_REC, 16'h8305, 1'b1);
      // A reset in mid-run must bring every written word back to its default
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      for (int i = 0; i < 8; i++)
         rdchk(idx_tab[i], rst_tab[i], 1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
